// >>> design/psel_pkg.sv
package psel_pkg;
	localparam int VAL_W = 16;
	localparam int PCT_W = 32;
	localparam int NUM_W = 29;
	localparam int SEL_W = 3;
	localparam int N_PRESET = 8;
	localparam int TICK_W = 16;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_MAX = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_SPEED = 8'h0c;
	localparam logic [7:0] OFS_PCT = 8'h10;
	localparam logic [7:0] OFS_PRESET0 = 8'h20;
	localparam int CTRL_REFL = 0;
	localparam int CTRL_INV = 1;
	localparam int CTRL_CLAMP = 2;
	localparam int STAT_IDX_LSB = 0;
	localparam int STAT_BUSY = 4;
	localparam int STAT_CLAMPED = 5;
	localparam int STAT_SEL_LSB = 8;
	localparam logic [2:0] CTRL_RESET = 3'h0;
	// speeds are in tenths of rpm, percentages in hundredths of a percent
	localparam logic [15:0] MAX_RESET = 16'h03e8;
	localparam logic [15:0] MAX_MIN = 16'h0001;
	localparam logic [15:0] MAX_MAX = 16'h7530;
	localparam logic signed [15:0] PRESET_LIM = 16'sh7530;
	localparam logic [15:0] PRESET_RESET = 16'h0000;
	localparam logic [13:0] PCT_SCALE = 14'h2710;
	localparam int CLK_PERIOD_PS = 5000;
	localparam int SCAN_PERIOD_NS = 1000;
	localparam int SCAN_CYCLES = SCAN_PERIOD_NS * 1000 / CLK_PERIOD_PS;
	typedef enum logic [1:0] {PSEL_BUS_IDLE = 2'b01, PSEL_BUS_WAIT = 2'b10} psel_bus_t;
	typedef enum logic [1:0] {PSEL_DIV_IDLE = 2'b01, PSEL_DIV_RUN = 2'b10} psel_div_t;
endpackage

// >>> design/psel_div.sv
`timescale 1ns/100ps
module psel_div #(
	parameter int NW = psel_pkg::NUM_W,
	parameter int DW = psel_pkg::VAL_W,
	parameter int RW = psel_pkg::PCT_W
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic start_in,
	input wire logic [NW-1:0] num_in,
	input wire logic [DW-1:0] den_in,
	input wire logic neg_in,
	output logic busy_out,
	output logic done_out,
	output logic [RW-1:0] quot_out
);
	import psel_pkg::*;
	localparam int CW = $clog2(NW + 1);

	if (NW < 2 || NW >= RW || DW < 2) begin : g_bad_width
		$error("psel_div: unsupported widths");
	end

	psel_div_t state_q, state_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic [DW-1:0] rem_q, rem_d, den_q, den_d;
	logic [NW-1:0] quo_q, quo_d, q_next;
	logic neg_q, neg_d, done_q, done_d;
	logic [RW-1:0] res_q, res_d, q_ext;
	logic [DW:0] trial;
	logic fit;

	// restoring division, one quotient bit per cycle; trades speed for a small area
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		rem_d = rem_q;
		den_d = den_q;
		quo_d = quo_q;
		neg_d = neg_q;
		done_d = 1'b0;
		res_d = res_q;
		trial = {rem_q, quo_q[NW-1]};
		fit = trial >= {1'b0, den_q};
		q_next = {quo_q[NW-2:0], fit};
		q_ext = RW'(q_next);
		case (state_q)
			PSEL_DIV_IDLE: begin
				if (start_in) begin
					state_d = PSEL_DIV_RUN;
					cnt_d = CW'(NW);
					rem_d = '0;
					den_d = den_in;
					quo_d = num_in;
					neg_d = neg_in;
				end
			end
			PSEL_DIV_RUN: begin
				rem_d = fit ? DW'(trial - {1'b0, den_q}) : trial[DW-1:0];
				quo_d = q_next;
				cnt_d = cnt_q - CW'(1);
				if (cnt_q == CW'(1)) begin
					state_d = PSEL_DIV_IDLE;
					done_d = 1'b1;
					res_d = neg_q ? -q_ext : q_ext;
				end
			end
			default: begin
				state_d = PSEL_DIV_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			state_q <= PSEL_DIV_IDLE;
			cnt_q <= '0;
			rem_q <= '0;
			den_q <= '0;
			quo_q <= '0;
			neg_q <= 1'b0;
			done_q <= 1'b0;
			res_q <= '0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			rem_q <= rem_d;
			den_q <= den_d;
			quo_q <= quo_d;
			neg_q <= neg_d;
			done_q <= done_d;
			res_q <= res_d;
		end
	end

	assign busy_out = (state_q == PSEL_DIV_RUN);
	assign done_out = done_q;
	assign quot_out = res_q;
endmodule

// >>> design/psel_top.sv
`timescale 1ns/100ps
// Behaviour
// R1 - one of eight presets chosen by selects
// R2 - binary msb select3; reflected order per table
// R3 - reflected decode when flag set, else binary
// R4 - source changes one select bit per step; psel_partner does so only with gray_in set, else it jumps straight to want_in
// R5 - invert flag negates selected preset
// R6 - clamp flag limits magnitude to max speed
// R7 - percent equals speed over max speed
// R8 - preset equal to max gives 100 percent
// R9 - invert then symmetric clamp, once per tick
module psel_top #(
	parameter int SCAN_CYCLES = psel_pkg::SCAN_CYCLES
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic [psel_pkg::SEL_W-1:0] sel_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	output logic [psel_pkg::SEL_W-1:0] index_out,
	output logic [psel_pkg::VAL_W-1:0] speed_out,
	output logic [psel_pkg::PCT_W-1:0] percent_out,
	output logic clamped_out
);
	import psel_pkg::*;

	if (SCAN_CYCLES < NUM_W + 8 || SCAN_CYCLES >= (1 << TICK_W)) begin : g_bad_scan
		$error("psel_top: scan period too short for the divider or too long");
	end

	function automatic logic psel_hit(input logic [31:0] a, input logic [7:0] ofs);
		psel_hit = (a == {24'h000000, ofs});
	endfunction

	function automatic logic psel_is_preset(input logic [31:0] a);
		psel_is_preset = (a[31:5] == {24'h000000, OFS_PRESET0[7:5]}) && (a[1:0] == 2'h0);
	endfunction

	function automatic logic [SEL_W-1:0] psel_decode(input logic [SEL_W-1:0] s, input logic refl);
		logic [SEL_W-1:0] b;
		b[2] = s[2];
		b[1] = s[2] ^ s[1];
		b[0] = s[2] ^ s[1] ^ s[0];
		psel_decode = refl ? b : s;
	endfunction

	function automatic logic [15:0] psel_lim_max(input logic [15:0] v);
		if (v < MAX_MIN) begin
			psel_lim_max = MAX_MIN;
		end else if (v > MAX_MAX) begin
			psel_lim_max = MAX_MAX;
		end else begin
			psel_lim_max = v;
		end
	endfunction

	function automatic logic [15:0] psel_lim_preset(input logic signed [15:0] v);
		if (v > PRESET_LIM) begin
			psel_lim_preset = PRESET_LIM;
		end else if (v < -PRESET_LIM) begin
			psel_lim_preset = -PRESET_LIM;
		end else begin
			psel_lim_preset = v;
		end
	endfunction

	// bus slave and configuration registers
	psel_bus_t bus_q, bus_d;
	logic [31:0] addr_q, addr_d, rdata_q, rdata_d, rd_word;
	logic wr_q, wr_d, ready_q, ready_d;
	logic [2:0] ctrl_q, ctrl_d;
	logic [15:0] max_q, max_d;
	logic [15:0] preset_q [N_PRESET];
	logic [15:0] preset_d [N_PRESET];

	// select pin synchroniser
	logic [SEL_W-1:0] s1_q, s2_q, s3_q, sel_q, sel_d;

	// scan tick divider
	logic [TICK_W-1:0] tick_cnt_q, tick_cnt_d;
	logic tick_q, tick_d;

	// datapath
	logic [SEL_W-1:0] sel_idx, index_q, index_d;
	logic signed [16:0] raw, inv, lim, maxs;
	logic signed [16:0] neg_raw;
	logic [15:0] speed_q, speed_d;
	// max held from the tick, so a later bus write cannot split percent from speed
	logic [15:0] maxl_q, maxl_d;
	logic clamped_q, clamped_d, go_q, go_d, lim_hit;
	logic [PCT_W-1:0] percent_q, percent_d, div_quot;
	logic [16:0] mag;
	logic [NUM_W-1:0] num;
	logic div_busy, div_done;

	always_comb begin
		rd_word = 32'h0;
		if (psel_hit(addr_q, OFS_CTRL)) begin
			rd_word[2:0] = ctrl_q;
		end else if (psel_hit(addr_q, OFS_MAX)) begin
			rd_word[15:0] = max_q;
		end else if (psel_hit(addr_q, OFS_STATUS)) begin
			rd_word[STAT_IDX_LSB +: SEL_W] = index_q;
			rd_word[STAT_BUSY] = div_busy;
			rd_word[STAT_CLAMPED] = clamped_q;
			rd_word[STAT_SEL_LSB +: SEL_W] = sel_q;
		end else if (psel_hit(addr_q, OFS_SPEED)) begin
			rd_word = {{16{speed_q[15]}}, speed_q};
		end else if (psel_hit(addr_q, OFS_PCT)) begin
			rd_word = percent_q;
		end else if (psel_is_preset(addr_q)) begin
			rd_word = {{16{preset_q[addr_q[4:2]][15]}}, preset_q[addr_q[4:2]]};
		end
	end

	// one wait state so that read data leaves a flip-flop
	always_comb begin
		bus_d = bus_q;
		addr_d = addr_q;
		wr_d = wr_q;
		rdata_d = rdata_q;
		ready_d = ready_q;
		ctrl_d = ctrl_q;
		max_d = max_q;
		preset_d = preset_q;
		case (bus_q)
			PSEL_BUS_IDLE: begin
				if (hsel_in && hready_in && htrans_in[1]) begin
					bus_d = PSEL_BUS_WAIT;
					addr_d = haddr_in;
					wr_d = hwrite_in;
					ready_d = 1'b0;
				end
			end
			PSEL_BUS_WAIT: begin
				bus_d = PSEL_BUS_IDLE;
				ready_d = 1'b1;
				rdata_d = wr_q ? 32'h0 : rd_word;
				if (wr_q) begin
					if (psel_hit(addr_q, OFS_CTRL)) begin
						ctrl_d = hwdata_in[2:0];
					end else if (psel_hit(addr_q, OFS_MAX)) begin
						max_d = psel_lim_max(hwdata_in[15:0]); // R7
					end else if (psel_is_preset(addr_q)) begin
						preset_d[addr_q[4:2]] = psel_lim_preset(hwdata_in[15:0]);
					end
				end
			end
			default: begin
				bus_d = PSEL_BUS_IDLE;
				ready_d = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			bus_q <= PSEL_BUS_IDLE;
			addr_q <= 32'h0;
			wr_q <= 1'b0;
			rdata_q <= 32'h0;
			ready_q <= 1'b1;
			ctrl_q <= CTRL_RESET;
			max_q <= MAX_RESET;
			for (int i = 0; i < N_PRESET; i++) begin
				preset_q[i] <= PRESET_RESET;
			end
		end else begin
			bus_q <= bus_d;
			addr_q <= addr_d;
			wr_q <= wr_d;
			rdata_q <= rdata_d;
			ready_q <= ready_d;
			ctrl_q <= ctrl_d;
			max_q <= max_d;
			preset_q <= preset_d;
		end
	end

	// a select change counts once the second and third stages agree
	always_comb begin
		sel_d = (s2_q == s3_q) ? s3_q : sel_q;
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			sel_q <= '0;
		end else begin
			s1_q <= sel_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			sel_q <= sel_d;
		end
	end

	always_comb begin
		tick_d = (tick_cnt_q == '0);
		tick_cnt_d = tick_d ? TICK_W'(SCAN_CYCLES - 1) : tick_cnt_q - TICK_W'(1);
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			tick_cnt_q <= '0;
			tick_q <= 1'b0;
		end else begin
			tick_cnt_q <= tick_cnt_d;
			tick_q <= tick_d;
		end
	end

	always_comb begin
		sel_idx = psel_decode(sel_q, ctrl_q[CTRL_REFL]); // R2 R3
		raw = {preset_q[sel_idx][15], preset_q[sel_idx]}; // R1
		neg_raw = -raw;
		inv = ctrl_q[CTRL_INV] ? neg_raw : raw; // R5
		maxs = {1'b0, max_q};
		lim = inv;
		lim_hit = 1'b0;
		// invert first so the clamp sees the final sign
		if (ctrl_q[CTRL_CLAMP] && inv > maxs) begin // R6 R9
			lim = maxs;
			lim_hit = 1'b1;
		end else if (ctrl_q[CTRL_CLAMP] && inv < -maxs) begin
			lim = -maxs;
			lim_hit = 1'b1;
		end
		index_d = index_q;
		speed_d = speed_q;
		clamped_d = clamped_q;
		maxl_d = maxl_q;
		go_d = tick_q;
		if (tick_q) begin // R9
			index_d = sel_idx;
			speed_d = lim[15:0];
			clamped_d = lim_hit;
			maxl_d = max_q; // R7
		end
		mag = speed_q[15] ? 17'(-{speed_q[15], speed_q}) : {1'b0, speed_q};
		num = {12'h000, mag} * {15'h0000, PCT_SCALE}; // R8
		percent_d = div_done ? div_quot : percent_q; // R7
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			index_q <= '0;
			speed_q <= '0;
			clamped_q <= 1'b0;
			maxl_q <= MAX_RESET;
			go_q <= 1'b0;
			percent_q <= '0;
		end else begin
			index_q <= index_d;
			speed_q <= speed_d;
			clamped_q <= clamped_d;
			maxl_q <= maxl_d;
			go_q <= go_d;
			percent_q <= percent_d;
		end
	end

	psel_div #(
		.NW(NUM_W),
		.DW(VAL_W),
		.RW(PCT_W)
	) u_div (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.start_in(go_q),
		.num_in(num),
		.den_in(maxl_q),
		.neg_in(speed_q[15]),
		.busy_out(div_busy),
		.done_out(div_done),
		.quot_out(div_quot)
	);

	assign hrdata_out = rdata_q;
	assign hreadyout_out = ready_q;
	assign hresp_out = 1'b0;
	assign index_out = index_q;
	assign speed_out = speed_q;
	assign percent_out = percent_q;
	assign clamped_out = clamped_q;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);

	logic signed [63:0] chk_pct, chk_spd, chk_max;
	assign chk_pct = {32'h0, percent_q[PCT_W-1] ? -percent_q : percent_q};
	assign chk_spd = $signed({47'h0, mag}) * 64'sd10000;
	assign chk_max = {48'h0, maxl_q};

	a_sel_route: assert property (tick_q && !ctrl_q[CTRL_INV] && !ctrl_q[CTRL_CLAMP]
		|=> speed_q == $past(raw[15:0])) else $error("preset not routed"); // R1
	a_bin_order: assert property (tick_q && !ctrl_q[CTRL_REFL]
		|=> index_q == $past(sel_q)) else $error("binary order wrong"); // R2
	a_refl_order: assert property (tick_q && ctrl_q[CTRL_REFL] && sel_q == 3'h4
		|=> index_q == 3'h7) else $error("reflected order wrong"); // R3
	a_sign_flip: assert property (tick_q && ctrl_q[CTRL_INV] && !ctrl_q[CTRL_CLAMP]
		|=> speed_q == $past(neg_raw[15:0])) else $error("sign not flipped"); // R5
	a_clamp_bound: assert property (tick_q && ctrl_q[CTRL_CLAMP] ##1 1'b1
		|-> $signed({speed_q[15], speed_q}) <= $signed({1'b0, $past(max_q)})
		&& $signed({speed_q[15], speed_q}) >= -$signed({1'b0, $past(max_q)}))
		else $error("clamp exceeded"); // R6
	a_pct_value: assert property (div_done
		|=> chk_pct * chk_max <= chk_spd && chk_spd < (chk_pct + 64'sd1) * chk_max)
		else $error("percent not speed over max"); // R7
	a_full_scale: assert property (div_done && speed_q == maxl_q
		|=> percent_q == 32'h00002710) else $error("full scale not 100 percent"); // R8
	a_inv_clamp: assert property (tick_q && ctrl_q[CTRL_INV] && ctrl_q[CTRL_CLAMP] && raw > maxs
		|=> speed_q == $past(-max_q)) else $error("invert before clamp broken"); // R9
	a_tick_update: assert property (tick_q |-> ##[2:40] div_done)
		else $error("no update within the scan"); // R9

	c_reflected: cover property (tick_q && ctrl_q[CTRL_REFL]);
	c_clamped: cover property (tick_q ##1 clamped_q);
	c_negative: cover property (div_done ##1 percent_q[PCT_W-1]);
endmodule

// >>> tb/psel_partner.sv
`timescale 1ns/100ps
module psel_partner (
	input wire logic clk_in,
	input wire logic [2:0] want_in,
	input wire logic gray_in,
	output logic [2:0] sel_out
);
	logic [2:0] pos_q;
	logic [2:0] pos_d;
	// gray mode walks one neighbour per clock, so a slow source never skips a step
	always_comb begin
		pos_d = pos_q;
		if (!gray_in) begin
			pos_d = want_in;
		end else if (pos_q < want_in) begin
			pos_d = pos_q + 3'h1;
		end else if (pos_q > want_in) begin
			pos_d = pos_q - 3'h1;
		end
	end
	always_ff @(posedge clk_in) begin
		pos_q <= pos_d;
	end
	assign sel_out = gray_in ? (pos_q ^ (pos_q >> 1)) : pos_q;
endmodule

// >>> tb/test_preset_speed_selector.sv
`timescale 1ns/100ps
module test_preset_speed_selector;
	import psel_pkg::*;
	localparam int SCAN = 40;
	localparam logic [2:0] GTAB [8] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h6, 3'h7, 3'h5, 3'h4};
	logic clk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [2:0] want = 3'h0;
	logic gray = 1'b0;
	logic [SEL_W-1:0] sel;
	logic [31:0] hrdata;
	logic hrdy;
	logic hresp;
	logic [SEL_W-1:0] idx;
	logic [VAL_W-1:0] speed;
	logic [PCT_W-1:0] pct;
	logic clamped;
	int mismatches = 0;
	int n_checks = 0;
	int cycles = 0;
	psel_partner u_src (.clk_in(clk_in), .want_in(want), .gray_in(gray), .sel_out(sel));
	psel_top #(.SCAN_CYCLES(SCAN)) u_dut (.clk_in(clk_in), .resetn_in(resetn_in),
		.sel_in(sel), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
		.hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy),
		.hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp), .index_out(idx),
		.speed_out(speed), .percent_out(pct), .clamped_out(clamped));
	initial forever #2.5 clk_in = ~clk_in;
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// hready is sampled at the edge, before that edge's updates land
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (hrdy !== 1'b1 && n < 50);
		if (hrdy !== 1'b1) begin
			mismatches++;
			test_done();
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input int v);
		logic [31:0] d;
		xfer(1'b1, a, v, d);
	endtask
	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		xfer(1'b0, a, 32'h0, d);
		check(what, d, exp);
	endtask
	// two full scans plus the divider latency: config is seen at a tick, percent follows
	task automatic settle();
		repeat (2 * SCAN + 45) @(posedge clk_in);
	endtask
	task automatic chk_out(input int s, input int mx, input logic cl);
		check("speed", {{16{speed[15]}}, speed}, s);
		check("percent", pct, s * 10000 / mx);
		check("clamped", {31'h0, clamped}, {31'h0, cl});
	endtask
	task automatic test_regs();
		rdchk("ctrl", OFS_CTRL, 32'h0);
		rdchk("max", OFS_MAX, {16'h0, MAX_RESET});
		rdchk("preset0", OFS_PRESET0, 32'h0);
		wr(8'h40, 32'h1234);
		rdchk("unmapped", 8'h40, 32'h0);
		wr(OFS_MAX, 0);
		rdchk("max_low", OFS_MAX, 32'h1);
		wr(OFS_MAX, 40000);
		rdchk("max_high", OFS_MAX, 32'h7530);
		check("hresp", {31'h0, hresp}, 32'h0);
	endtask
	task automatic test_binary();
		wr(OFS_MAX, 30000);
		wr(OFS_CTRL, 0);
		for (int i = 0; i < 8; i++) wr(8'(OFS_PRESET0 + 4 * i), (i + 1) * 100 - 400);
		for (int i = 0; i < 8; i++) begin
			want <= 3'(i);
			settle();
			check("bin_index", {29'h0, idx}, i);
			chk_out((i + 1) * 100 - 400, 30000, 1'b0);
		end
	endtask
	task automatic test_gray();
		wr(OFS_CTRL, 1);
		gray <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			want <= 3'(i);
			settle();
			check("gray_pins", {29'h0, sel}, {29'h0, GTAB[i]});
			check("gray_index", {29'h0, idx}, i);
			chk_out((i + 1) * 100 - 400, 30000, 1'b0);
		end
		gray <= 1'b0;
	endtask
	task automatic test_shape();
		int tc[8] = '{0, 2, 6, 4, 4, 2, 6, 0};
		int tp[8] = '{1000, 2500, 2500, -2500, 999, 333, -30000, 30000};
		int tm[8] = '{1000, 1000, 1000, 1000, 1000, 1000, 1, 30000};
		int ts[8] = '{1000, -2500, -1000, -1000, 999, -333, 1, 30000};
		logic tl[8] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
		want <= 3'h5;
		for (int k = 0; k < 8; k++) begin
			wr(OFS_CTRL, tc[k]);
			wr(8'(OFS_PRESET0 + 20), tp[k]);
			wr(OFS_MAX, tm[k]);
			settle();
			check("shape_index", {29'h0, idx}, 32'h5);
			chk_out(ts[k], tm[k], tl[k]);
			rdchk("speed_reg", OFS_SPEED, ts[k]);
			rdchk("pct_reg", OFS_PCT, ts[k] * 10000 / tm[k]);
		end
	endtask
	initial begin
		repeat (3) @(posedge clk_in);
		resetn_in <= 1'b1;
		check("reset_index", {29'h0, idx}, 32'h0);
		test_regs();
		test_binary();
		test_gray();
		test_shape();
		test_done();
	end
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			test_done();
		end
	end
endmodule
